// ===== hw/hai_pkg.sv
`default_nettype none
package hai_pkg;
  // clock rate and derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int SYNC_LAT = 2;
  localparam int T_ACQ_NS = 160;
  localparam int T_WAKE_NS = 360;
  localparam int T_WR_NS = 250;
  localparam int T_RD_GAP_NS = 250;
  localparam int T_ACC2_NS = 130;
  localparam int T_ACC1_NS = 205;
  localparam int T_RM_ACC_NS = 130;
  localparam int CNT_W = 8;
  localparam int RES_W = 8;
  localparam int NIB_W = 4;

  // least time rounded up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int ACQ_CYC = ns_to_cyc(T_ACQ_NS);
  localparam int WAKE_CYC = ns_to_cyc(T_WAKE_NS);
  localparam int WR_CYC = ns_to_cyc(T_WR_NS);
  localparam int RD_GAP_CYC = ns_to_cyc(T_RD_GAP_NS);
  localparam int ACC2_CYC = ns_to_cyc(T_ACC2_NS) + SYNC_LAT;
  localparam int ACC1_CYC = ns_to_cyc(T_ACC1_NS) + SYNC_LAT;
  localparam int RM_ACC_CYC = ns_to_cyc(T_RM_ACC_NS) + SYNC_LAT;

  // interface modes on the mode pin
  localparam logic MODE_READ = 1'h0;
  localparam logic MODE_WRITE_READ = 1'h1;

  // pins driven toward the converter
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic wr_oe;
    logic mode;
    logic sleep_request_n;
  } hai_pins_type;

  localparam hai_pins_type PINS_RST = '{cs_n: 1'h1, rd_n: 1'h1, wr_n: 1'h1,
    wr_oe: 1'h0, mode: 1'h0, sleep_request_n: 1'h1};

  // pins sensed from the converter
  typedef struct packed {
    logic int_n;
    logic ready;
    logic [RES_W-1:0] result_bus;
  } hai_sense_type;

  localparam hai_sense_type SENSE_RST = '{int_n: 1'h1, ready: 1'h1, result_bus: '0};
endpackage : hai_pkg
`default_nettype wire

// ===== hw/hai_sync.sv
`default_nettype none
module hai_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else if (i_clk_en)
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule : hai_sync
`default_nettype wire

// ===== hw/hai_host.sv
// Overview of operation
// - chip select stays high while asleep
// - other inputs held steady while asleep
// - first conversion 360ns after wake
// - read mode: track 160ns before converting
// - read strobe low starts read-mode conversion
// - external timing: read 250ns after write
// - 160ns after end flag before next write
// - internal delay: wait end flag, then read
`default_nettype none
module hai_host (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // user side
  input wire logic i_start,
  input wire logic i_mode_wr,
  input wire logic i_fast,
  input wire logic i_sleep,
  output logic o_busy,
  output logic o_asleep,
  output logic o_done,
  output logic [hai_pkg::RES_W-1:0] o_result,
  // converter pins
  output hai_pkg::hai_pins_type o_pins,
  input wire logic i_wr_rdy,
  input wire logic i_int_n,
  input wire logic [hai_pkg::RES_W-1:0] i_result_bus
);
  import hai_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SLEEP, ST_WAKE, ST_ACQ, ST_RM_RD, ST_RM_ACC,
    ST_WM_WR, ST_WM_GAP, ST_WM_RD, ST_FIN
  } hai_state_type;

  if (ACC1_CYC >= (1 << CNT_W) || WAKE_CYC >= (1 << CNT_W))
  begin : g_cnt_check
    $error("counter too narrow");
  end

  hai_state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic mode_q, mode_d;
  logic fast_q, fast_d;
  logic done_q, done_d;
  logic [RES_W-1:0] result_q, result_d;
  hai_pins_type pins_q, pins_d;
  hai_sense_type sense_raw, sense_s;

  assign sense_raw = '{int_n: i_int_n, ready: i_wr_rdy, result_bus: i_result_bus};

  // end flag and ready reset to their idle high level so no false end follows reset
  hai_sync #(.WIDTH($bits(hai_sense_type)), .RST_VAL(SENSE_RST)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_async(sense_raw),
    .o_sync(sense_s)
  );

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n);
  endfunction : cyc

  always_comb
  begin
    state_d = state_q;
    cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
    mode_d = mode_q;
    fast_d = fast_q;
    done_d = 1'b0;
    result_d = result_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (i_sleep)
          state_d = ST_SLEEP;
        else if (i_start)
        begin
          mode_d = i_mode_wr;
          fast_d = i_fast;
          if (i_mode_wr == MODE_WRITE_READ)
          begin
            state_d = ST_WM_WR;
            cnt_d = cyc(WR_CYC);
          end
          else
            state_d = ST_RM_RD;
        end
        else
          mode_d = i_mode_wr;
      end
      ST_SLEEP:
        if (!i_sleep)
        begin
          state_d = ST_WAKE;
          cnt_d = cyc(WAKE_CYC);
        end
      ST_WAKE:
        if (cnt_q == '0)
          state_d = ST_IDLE;
      ST_ACQ:
        if (cnt_q == '0)
          state_d = ST_IDLE;
      ST_RM_RD:
        if (!sense_s.int_n)
        begin
          state_d = ST_RM_ACC;
          cnt_d = cyc(RM_ACC_CYC);
        end
      ST_RM_ACC:
        if (cnt_q == '0)
        begin
          result_d = sense_s.result_bus;
          state_d = ST_FIN;
        end
      ST_WM_WR:
        if (cnt_q == '0)
        begin
          state_d = ST_WM_GAP;
          cnt_d = cyc(RD_GAP_CYC);
        end
      ST_WM_GAP:
        if (fast_q ? (cnt_q == '0) : !sense_s.int_n)
        begin
          state_d = ST_WM_RD;
          cnt_d = fast_q ? cyc(ACC1_CYC) : cyc(ACC2_CYC);
        end
      ST_WM_RD:
        if (cnt_q == '0)
        begin
          result_d = sense_s.result_bus;
          state_d = ST_FIN;
        end
      ST_FIN:
      begin
        done_d = 1'b1;
        state_d = ST_ACQ;
        cnt_d = cyc(ACQ_CYC);
      end
    endcase
  end

  // pin levels follow the next state so that they leave flip-flops
  always_comb
  begin
    pins_d = PINS_RST;
    pins_d.mode = mode_d;
    pins_d.wr_oe = (mode_d == MODE_WRITE_READ);
    unique case (state_d)
      ST_SLEEP, ST_WAKE:
      begin
        pins_d.sleep_request_n = (state_d == ST_WAKE);
        pins_d.mode = mode_q;
        pins_d.wr_oe = (mode_q == MODE_WRITE_READ);
      end
      ST_RM_RD, ST_RM_ACC:
      begin
        pins_d.cs_n = 1'b0;
        pins_d.rd_n = 1'b0;
      end
      ST_WM_WR:
      begin
        pins_d.cs_n = 1'b0;
        pins_d.wr_n = 1'b0;
      end
      ST_WM_GAP:
        pins_d.cs_n = 1'b0;
      ST_WM_RD:
      begin
        pins_d.cs_n = 1'b0;
        pins_d.rd_n = 1'b0;
      end
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      mode_q <= MODE_READ;
      fast_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= '0;
      pins_q <= PINS_RST;
    end
    else if (i_clk_en)
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      fast_q <= fast_d;
      done_q <= done_d;
      result_q <= result_d;
      pins_q <= pins_d;
    end
  end

  assign o_pins = pins_q;
  assign o_result = result_q;
  assign o_done = done_q;
  assign o_busy = (state_q != ST_IDLE);
  assign o_asleep = (state_q == ST_SLEEP);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_sleep_enter;
    i_clk_en && state_q == ST_IDLE && i_sleep;
  endsequence
  sequence s_wr_done;
    i_clk_en && state_q == ST_WM_WR && cnt_q == '0;
  endsequence

  chk_sleep_cs_high: assert property (
    !o_pins.sleep_request_n |-> o_pins.cs_n)
    else $error("chip select low during sleep");
  chk_sleep_pins_stable: assert property (
    !o_pins.sleep_request_n && !$past(o_pins.sleep_request_n)
      |-> $stable(o_pins.mode) && o_pins.rd_n && o_pins.wr_n)
    else $error("inputs moved during sleep");
  chk_sleep_entry: assert property (
    s_sleep_enter |=> !o_pins.sleep_request_n)
    else $error("sleep request not lowered");
  chk_wake_wait: assert property (
    $rose(o_pins.sleep_request_n) |-> (o_pins.cs_n) [*8])
    else $error("conversion too soon after wake");
  chk_wake_count: assert property (
    i_clk_en && state_q == ST_SLEEP && !i_sleep |=> cnt_q == cyc(WAKE_CYC))
    else $error("wake count wrong");
  chk_wr_pulse: assert property (
    s_wr_done |=> o_pins.wr_n && !o_pins.cs_n)
    else $error("write strobe not released");
  chk_acq_gap: assert property (
    $rose(o_pins.cs_n) |-> (o_pins.rd_n && o_pins.wr_n) [*8])
    else $error("next conversion too soon");
  chk_acq_load: assert property (
    i_clk_en && state_q == ST_FIN |=> state_q == ST_ACQ && cnt_q == cyc(ACQ_CYC))
    else $error("acquisition wait not loaded");
  chk_wr_oe_mode: assert property (
    o_pins.wr_oe == (o_pins.mode == MODE_WRITE_READ))
    else $error("shared pin drive wrong for mode");
  chk_fast_gap: assert property (
    s_wr_done and fast_q |=> (o_pins.rd_n) [*8])
    else $error("read strobe too early");
  chk_strobe_cs: assert property (
    !o_pins.rd_n || !o_pins.wr_n |-> !o_pins.cs_n)
    else $error("strobe without chip select");
endmodule : hai_host
`default_nettype wire

// ===== test/hai_adc_model.sv
`default_nettype none
module hai_adc_model (
  // host pins
  input wire hai_pkg::hai_pins_type i_pins,
  input wire logic [7:0] i_sample,
  // converter outputs
  output logic o_rdy_low,
  output logic o_int_n,
  output logic [7:0] o_result_bus,
  output logic o_viol
);
  timeunit 1ns;
  timeprecision 100ps;
  import hai_pkg::*;
  logic [7:0] res = 8'h00;
  logic busy_rd = 1'b0;
  logic pend = 1'b0;
  logic dv = 1'b0;
  realtime t_wake = -1000.0;
  realtime t_end = -1000.0;
  logic slept = 1'b0;
  wire logic en = !i_pins.cs_n && i_pins.sleep_request_n;
  // edge processes read the pins directly: the net above may lag the edge
  function automatic logic live();
    return !i_pins.cs_n && i_pins.sleep_request_n;
  endfunction : live
  initial o_int_n = 1'b1;
  initial o_viol = 1'b0;
  assign o_rdy_low = (!i_pins.mode && busy_rd) ||
    (!i_pins.sleep_request_n && !i_pins.cs_n);
  // released bus shows the inverse so an early sample cannot match
  assign o_result_bus = (en && !i_pins.rd_n && dv && !pend && !busy_rd) ? res : ~res;
  task automatic begin_conv();
    if ($realtime - t_wake < 360.0 || $realtime - t_end < 160.0) o_viol = 1'b1;
  endtask : begin_conv
  task automatic end_conv();
    res[3:0] = i_sample[3:0];
    pend = 1'b0;
    busy_rd = 1'b0;
    o_int_n = 1'b0;
    t_end = $realtime;
  endtask : end_conv
  always @(negedge i_pins.sleep_request_n)
  begin
    if (!i_pins.cs_n) o_viol = 1'b1;
    slept = 1'b1;
  end
  // the first rise out of an unknown level after reset is not a wake-up
  always @(posedge i_pins.sleep_request_n) if (slept) t_wake = $realtime;
  always @(posedge i_pins.cs_n or posedge i_pins.rd_n) o_int_n = 1'b1;
  always @(posedge i_pins.rd_n) dv = 1'b0;
  always @(negedge i_pins.rd_n)
  begin
    dv = 1'b0;
    if (live() && !i_pins.mode)
    begin
      begin_conv();
      res[7:4] = i_sample[7:4];
      busy_rd = 1'b1;
      #600 end_conv();
    end
    else if (live() && pend) end_conv();
    #100 dv = 1'b1;
  end
  always @(negedge i_pins.wr_n) if (live() && i_pins.mode) begin_conv();
  always @(posedge i_pins.wr_n)
  begin
    if (live() && i_pins.mode)
    begin
      res[7:4] = i_sample[7:4];
      pend = 1'b1;
      #380 if (pend) end_conv();
    end
  end
endmodule : hai_adc_model
`default_nettype wire

// ===== test/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hai_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_start = 1'b0;
  logic i_mode_wr = 1'b0;
  logic i_fast = 1'b0;
  logic i_sleep = 1'b0;
  logic clk_en = 1'b1;
  logic o_busy, o_asleep, o_done, rdy_low, int_n, viol;
  logic [RES_W-1:0] o_result, result_bus;
  logic [7:0] sample = 8'h00;
  hai_pins_type o_pins;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int total_checks = 0;
  // shared pin: host strobe, else open-collector ready with pull-up
  wire logic wr_rdy = o_pins.wr_oe ? o_pins.wr_n : !rdy_low;
  always #5 i_sys_clk = ~i_sys_clk;
  hai_host hai_host_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(clk_en),
    .i_start(i_start), .i_mode_wr(i_mode_wr), .i_fast(i_fast), .i_sleep(i_sleep),
    .o_busy(o_busy), .o_asleep(o_asleep), .o_done(o_done), .o_result(o_result),
    .o_pins(o_pins), .i_wr_rdy(wr_rdy), .i_int_n(int_n), .i_result_bus(result_bus));
  hai_adc_model hai_adc_model_i (.i_pins(o_pins), .i_sample(sample), .o_rdy_low(rdy_low),
    .o_int_n(int_n), .o_result_bus(result_bus), .o_viol(viol));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : step
  task automatic wait_for(input logic done_not_idle);
    int n;
    n = 0;
    while ((done_not_idle ? o_done : !o_busy) !== 1'b1 && n < 500)
    begin
      step(1);
      n++;
    end
    if (n >= 500)
    begin
      check(8'h00, 8'h01);
      end_of_test();
    end
  endtask : wait_for
  task automatic convert(input logic mw, input logic fast);
    sample = 8'($urandom);
    exp_q.push_back(sample);
    i_mode_wr = mw;
    i_fast = fast;
    i_start = 1'b1;
    step(1);
    i_start = 1'b0;
    step(1);
    check(o_busy, 1'b1);
    check(o_pins.mode, mw);
    check({o_pins.cs_n, mw ? o_pins.wr_n : o_pins.rd_n}, 8'h00);
    wait_for(1'b1);
    check(o_result, exp_q.pop_front());
    step(1);
    check(o_busy, 1'b1);
    check(int_n, 1'b1);
    wait_for(1'b0);
  endtask : convert
  initial
  begin
    void'($urandom(32'h66BA632E));
    step(20);
    i_nrst = 1'b1;
    check({o_pins.mode, o_pins.wr_oe, o_pins.cs_n}, 8'h01);
    for (int k = 0; k < 12; k++) convert(k % 3 != 0, k % 3 == 2);
    clk_en = 1'b0;
    i_start = 1'b1;
    step(3);
    check({o_busy, o_pins.cs_n, o_pins.rd_n, o_pins.wr_n}, 8'h07);
    i_start = 1'b0;
    clk_en = 1'b1;
    i_sleep = 1'b1;
    step(2);
    check(o_asleep, 1'b1);
    check({o_pins.sleep_request_n, o_pins.cs_n}, 8'h01);
    i_start = 1'b1;
    step(3);
    check({o_pins.cs_n, o_pins.rd_n, o_pins.wr_n}, 8'h07);
    i_start = 1'b0;
    i_sleep = 1'b0;
    step(2);
    i_start = 1'b1;
    step(1);
    i_start = 1'b0;
    wait_for(1'b0);
    check({o_pins.sleep_request_n, o_pins.cs_n, o_busy}, 8'h06);
    convert(1'b1, 1'b0);
    convert(1'b0, 1'b0);
    check(viol, 1'b0);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
